// ---- bench/tb_top.sv ----
// Self-checking bench for the clamp and level control.
`timescale 1ns/1ns
`default_nettype none
`include "vct_params.svh"
module tb_top;
  import vct_pkg::*;
  logic clk, rst_b, sclIn, sdaM, addrPin, lineGo, strobeLvl, sdaOut, sdaOe_b;
  logic lineSync, clampStrobe, greenSyncInput, clampActive, greenSyncDetect;
  logic [7:0] level, redFullScale, greenFullScale, blueFullScale;
  logic [6:0] redLevelShift, greenLevelShift, blueLevelShift;
  logic [1:0] bandwidthSel;
  logic [4:0] greenSyncThreshold;
  code_t redRaw, greenRaw, blueRaw, redCode, greenCode, blueCode;
  wire sdaIn;
  int errors, n_compared, cycles, d1;
  assign sdaIn = sdaM & (sdaOe_b | sdaOut);
  vct_clamp_level_ctrl dut (.clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .addrPin(addrPin), .lineSync(lineSync),
    .clampStrobe(clampStrobe), .greenSyncInput(greenSyncInput), .redRaw(redRaw),
    .greenRaw(greenRaw), .blueRaw(blueRaw), .redCode(redCode), .greenCode(greenCode),
    .blueCode(blueCode), .clampActive(clampActive), .redFullScale(redFullScale),
    .greenFullScale(greenFullScale), .blueFullScale(blueFullScale),
    .redLevelShift(redLevelShift), .greenLevelShift(greenLevelShift),
    .blueLevelShift(blueLevelShift), .bandwidthSel(bandwidthSel),
    .greenSyncThreshold(greenSyncThreshold), .greenSyncDetect(greenSyncDetect));
  vct_video_src src (.clk(clk), .lineGo(lineGo), .strobeLvl(strobeLvl), .level(level),
    .lineSync(lineSync), .clampStrobe(clampStrobe), .greenSyncInput(greenSyncInput),
    .redRaw(redRaw), .greenRaw(greenRaw), .blueRaw(blueRaw));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chkV(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkN(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %0t count %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic sbit(input logic b);
    sdaM = b;
    tick(2);
    sclIn = 1'b1;
    tick(5);
    sclIn = 1'b0;
    tick(3);
  endtask
  task automatic rbit(output logic b);
    sdaM = 1'b1;
    tick(2);
    sclIn = 1'b1;
    tick(3);
    b = sdaIn;
    tick(2);
    sclIn = 1'b0;
    tick(3);
  endtask
  task automatic pstart;
    sdaM = 1'b1;
    tick(2);
    sclIn = 1'b1;
    tick(5);
    sdaM = 1'b0;
    tick(5);
    sclIn = 1'b0;
    tick(3);
  endtask
  task automatic pstop;
    sdaM = 1'b0;
    tick(2);
    sclIn = 1'b1;
    tick(5);
    sdaM = 1'b1;
    tick(5);
  endtask
  task automatic wrByte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) sbit(v[i]);
    rbit(b);
    ack = ~b;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    pstart();
    wrByte({`VCT_DEV_ADDR_BASE, addrPin, 1'b0}, k0);
    wrByte(a, k1);
    wrByte(d, k2);
    pstop();
    chkV({5'h00, k0, k1, k2}, 8'h07);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic k0, k1, k2;
    logic [7:0] d;
    pstart();
    wrByte({`VCT_DEV_ADDR_BASE, addrPin, 1'b0}, k0);
    wrByte(a, k1);
    pstart();
    wrByte({`VCT_DEV_ADDR_BASE, addrPin, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    sbit(1'b1);
    pstop();
    chkV({5'h00, k0, k1, k2}, 8'h07);
    chkV(d, exp);
  endtask
  task automatic pulseLine;
    lineGo = 1'b1;
    tick(1);
    lineGo = 1'b0;
  endtask
  // Delay is counted from a fixed point after the sync trailing edge.
  task automatic lineRun(output int dly, output int len);
    pulseLine();
    tick(9);
    dly = 0;
    while (clampActive !== 1'b1 && dly < 600) begin
      tick(1);
      dly++;
    end
    len = 0;
    while (clampActive === 1'b1 && len < 600) begin
      tick(1);
      len++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic regTest;
    logic [7:0] offs [8] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] init [8] = '{8'h08, 8'h14, 8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h40};
    logic k;
    for (int i = 0; i < 8; i++) rdChk(offs[i], init[i]);
    regWrite(8'h08, 8'h01);
    regWrite(8'h09, 8'hfe);
    regWrite(8'h0a, 8'h5a);
    regWrite(8'h0b, 8'h00);
    regWrite(8'h0c, 8'h7f);
    regWrite(8'h0d, 8'h41);
    chkV(redFullScale, 8'h01);
    chkV(greenFullScale, 8'hfe);
    chkV(blueFullScale, 8'h5a);
    chkV({1'b0, redLevelShift}, 8'h41);
    chkV({1'b0, greenLevelShift}, 8'h3f);
    chkV({1'b0, blueLevelShift}, 8'h01);
    rdChk(8'h0b, 8'h00);
    rdChk(8'h0c, 8'h7f);
    rdChk(8'h20, 8'h00);
    pstart();
    wrByte({~`VCT_DEV_ADDR_BASE, addrPin, 1'b0}, k);
    pstop();
    chkV({7'h00, k}, 8'h00);
  endtask
  task automatic genTest;
    int d, n;
    regWrite(8'h05, 8'h03);
    regWrite(8'h06, 8'h05);
    lineRun(d1, n);
    chkN(n, 5);
    regWrite(8'h05, 8'hff);
    regWrite(8'h06, 8'hff);
    lineRun(d, n);
    chkN(d - d1, 252);
    chkN(n, 255);
    regWrite(8'h06, 8'h00);
    lineRun(d, n);
    chkN(n, 0);
  endtask
  task automatic abandonTest;
    int n;
    regWrite(8'h05, 8'h02);
    regWrite(8'h06, 8'h64);
    pulseLine();
    tick(30);
    pulseLine();
    tick(7 + d1);
    chkV({7'h00, clampActive}, 8'h00);
    tick(1);
    n = 0;
    while (clampActive === 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    chkN(n, 100);
  endtask
  task automatic trimTest;
    int d, n;
    regWrite(8'h06, 8'hff);
    regWrite(8'h10, 8'h82);
    lineRun(d, n);
    tick(4);
    chkV(redCode, 8'h80);
    chkV(greenCode, 8'h00);
    chkV(blueCode, 8'h00);
    regWrite(8'h10, 8'h86);
    lineRun(d, n);
    tick(4);
    chkV(blueCode, 8'h80);
    level = 8'h30;
    tick(4);
    chkV(greenCode, 8'h10);
    chkV(redCode, 8'h90);
  endtask
  task automatic extTest;
    regWrite(8'h0f, 8'h80);
    chkV({7'h00, clampActive}, 8'h00);
    strobeLvl = 1'b1;
    tick(5);
    chkV({7'h00, clampActive}, 8'h01);
    strobeLvl = 1'b0;
    tick(5);
    chkV({7'h00, clampActive}, 8'h00);
    regWrite(8'h0f, 8'hc0);
    chkV({7'h00, clampActive}, 8'h01);
    strobeLvl = 1'b1;
    tick(5);
    chkV({7'h00, clampActive}, 8'h00);
    regWrite(8'h0f, 8'h00);
  endtask
  task automatic bwTest;
    for (int w = 0; w < 4; w++) begin
      regWrite(8'h0e, w[7:0]);
      chkV({6'h00, bandwidthSel}, w[7:0]);
    end
    chkV({3'h0, greenSyncThreshold}, 8'h10);
    regWrite(8'h10, 8'hf8);
    chkV({3'h0, greenSyncThreshold}, 8'h1f);
  endtask
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {sclIn, sdaM, addrPin, lineGo, strobeLvl, rst_b} = 6'h38;
    level = 8'h20;
    tick(2);
    rst_b = 1'b1;
    tick(3);
    regTest();
    genTest();
    abandonTest();
    trimTest();
    extTest();
    bwTest();
    wrap_up();
  end
endmodule
bind vct_clamp_level_ctrl vct_chk chk (.clk(clk), .rst_b(rst_b), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .lineSync(lineSync), .greenSyncInput(greenSyncInput),
  .clampActive(clampActive), .redFullScale(redFullScale), .greenFullScale(greenFullScale),
  .blueFullScale(blueFullScale), .redLevelShift(redLevelShift),
  .greenLevelShift(greenLevelShift), .blueLevelShift(blueLevelShift),
  .bandwidthSel(bandwidthSel), .greenSyncThreshold(greenSyncThreshold),
  .greenSyncDetect(greenSyncDetect));
`default_nettype wire

// ---- bench/vct_chk.sv ----
// Port checker for the clamp and level control.
`timescale 1ns/1ns
`default_nettype none
module vct_chk (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset.
  input wire logic sclIn, // Serial clock.
  input wire logic sdaOut, // Data value.
  input wire logic sdaOe_b, // Data enable.
  input wire logic lineSync, // Line sync.
  input wire logic greenSyncInput, // Green sync pin.
  input wire logic clampActive, // Clamp.
  input wire logic [7:0] redFullScale, // Red gain.
  input wire logic [7:0] greenFullScale, // Green gain.
  input wire logic [7:0] blueFullScale, // Blue gain.
  input wire logic [6:0] redLevelShift, // Red shift.
  input wire logic [6:0] greenLevelShift, // Green shift.
  input wire logic [6:0] blueLevelShift, // Blue shift.
  input wire logic [1:0] bandwidthSel, // Bandwidth.
  input wire logic [4:0] greenSyncThreshold, // Threshold.
  input wire logic greenSyncDetect // Sync seen.
);
  logic [8:0] hiCnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Counts consecutive clamp cycles.
  always_ff @(posedge clk) begin
    if (!rst_b || !clampActive) begin
      hiCnt <= 9'h000;
    end else if (hiCnt != 9'h1ff) begin
      hiCnt <= hiCnt + 9'h001;
    end
  end
  sequence busIdle;
    sclIn [*8];
  endsequence
  sequence greenLow;
    !greenSyncInput [*5];
  endsequence
  sequence greenHigh;
    greenSyncInput [*5];
  endsequence
  shift_range_a: assert property ((redLevelShift != 7'h40) &&
    (greenLevelShift != 7'h40) && (blueLevelShift != 7'h40))
    else $error("level shift below -63");
  sync_low_a: assert property (greenLow |-> greenSyncDetect)
    else $error("green sync missed");
  sync_high_a: assert property (greenHigh |-> !greenSyncDetect)
    else $error("green sync false");
  clamp_max_a: assert property (hiCnt <= 9'h0ff)
    else $error("clamp longer than 255");
  clamp_abandon_a: assert property ($fell(lineSync) && clampActive |-> ##[1:6] !clampActive)
    else $error("clamp not abandoned");
  sda_value_a: assert property (!sdaOe_b |-> !sdaOut)
    else $error("data driven high");
  sda_edge_a: assert property ($changed(sdaOe_b) |-> !sclIn && !$past(sclIn))
    else $error("data moved with clock high");
  cfg_stable_a: assert property (busIdle |-> $stable({redFullScale, greenFullScale,
    blueFullScale, redLevelShift, greenLevelShift, blueLevelShift, bandwidthSel,
    greenSyncThreshold})) else $error("setting changed while port idle");
endmodule
`default_nettype wire

// ---- bench/vct_video_src.sv ----
// Graphics source model: line sync, clamp strobe and black-level codes.
`timescale 1ns/1ns
`default_nettype none
module vct_video_src
  import vct_pkg::*;
(
  input wire logic clk, // Pixel clock.
  input wire logic lineGo, // Starts one sync pulse.
  input wire logic strobeLvl, // Wanted strobe level.
  input wire logic [7:0] level, // Black level code.
  output logic lineSync, // Line sync.
  output logic clampStrobe, // Clamp strobe.
  output logic greenSyncInput, // Green sync pin.
  output code_t redRaw, // Red code.
  output code_t greenRaw, // Green code.
  output code_t blueRaw // Blue code.
);
  logic [3:0] cnt = 4'h0;
  // Sync lasts eight pixel periods.
  always @(posedge clk) begin
    if (lineGo) begin
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign lineSync = (cnt != 4'h0);
  assign greenSyncInput = !lineSync;
  // The sync tip reads as code zero, black is the programmed level.
  assign redRaw = lineSync ? 8'h00 : level;
  assign greenRaw = lineSync ? 8'h00 : level;
  assign blueRaw = lineSync ? 8'h00 : level;
  assign clampStrobe = strobeLvl;
endmodule
`default_nettype wire

// ---- hw/vct_clamp_level_ctrl.sv ----
// Clamp window generator, channel level control and two-wire register port.
`include "vct_params.svh"
`timescale 1ns/1ns
`default_nettype none

module vct_clamp_level_ctrl (
  input wire logic clk,                        // Pixel clock, 20 MHz.
  input wire logic rst_b,                      // Synchronous reset, active low.
  input wire logic sclIn,                      // Serial port clock pin.
  input wire logic sdaIn,                      // Serial port data pin, input side.
  output logic sdaOut,                         // Serial port data, output side, always low.
  output logic sdaOe_b,                        // Serial data enable, low while pulling low.
  input wire logic addrPin,                    // Serial address select pin.
  input wire logic lineSync,                   // Line sync pin, active high.
  input wire logic clampStrobe,                // External clamp strobe pin.
  input wire logic greenSyncInput,             // Green sync comparator pin, low in sync.
  input wire vct_pkg::code_t redRaw,           // Red converter code before trim.
  input wire vct_pkg::code_t greenRaw,         // Green converter code before trim.
  input wire vct_pkg::code_t blueRaw,          // Blue converter code before trim.
  output vct_pkg::code_t redCode,              // Red code after clamp trim.
  output vct_pkg::code_t greenCode,            // Green code after clamp trim.
  output vct_pkg::code_t blueCode,             // Blue code after clamp trim.
  output logic clampActive,                    // Clamp interval in force.
  output logic [7:0] redFullScale,             // Red full-scale setting.
  output logic [7:0] greenFullScale,           // Green full-scale setting.
  output logic [7:0] blueFullScale,            // Blue full-scale setting.
  output logic [6:0] redLevelShift,            // Red level shift, signed LSB.
  output logic [6:0] greenLevelShift,          // Green level shift, signed LSB.
  output logic [6:0] blueLevelShift,           // Blue level shift, signed LSB.
  output logic [1:0] bandwidthSel,             // Analog bandwidth select.
  output logic [4:0] greenSyncThreshold,       // Green sync slicer threshold.
  output logic greenSyncDetect                 // Green sync seen, active high.
);
  import vct_pkg::*;

  vct_state_s st;
  vct_state_s next_st;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] readReg(input vct_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `VCT_REG_CLAMP_START_DELAY: v = s.clampStart;
      `VCT_REG_CLAMP_LENGTH: v = s.clampLength;
      `VCT_REG_RED_FULL_SCALE: v = s.fullScale[0];
      `VCT_REG_GREEN_FULL_SCALE: v = s.fullScale[1];
      `VCT_REG_BLUE_FULL_SCALE: v = s.fullScale[2];
      `VCT_REG_RED_LEVEL_SHIFT: v = {1'b0, s.levelShift[0]};
      `VCT_REG_GREEN_LEVEL_SHIFT: v = {1'b0, s.levelShift[1]};
      `VCT_REG_BLUE_LEVEL_SHIFT: v = {1'b0, s.levelShift[2]};
      `VCT_REG_BANDWIDTH: v = {6'h00, s.bandwidth};
      `VCT_REG_CLAMP_CTRL: v = s.clampCtrl;
      `VCT_REG_SYNC_CTRL: v = s.syncCtrl;
      `VCT_REG_STATUS: v = {5'h00, s.greenSyncDetect, s.lineSyncS[1], s.clampActive};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Level shift code to signed LSB; code 0x40 is zero, code 0 saturates to -63.
  function automatic logic [6:0] shiftLsb(input logic [6:0] c);
    logic [6:0] d;
    d = c - `VCT_LEVEL_SHIFT_ZERO;
    if (d == 7'h40) begin
      d = `VCT_LEVEL_SHIFT_MIN;
    end
    return d;
  endfunction

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic syncTrail;
  logic extClamp;
  logic clampNow;
  logic [7:0] readData;
  logic [2:0][7:0] rawCode;
  logic [2:0][7:0] target;
  logic [2:0] midSel;

  assign rawCode = {blueRaw, greenRaw, redRaw};

  always_comb begin
    logic [9:0] sum;
    sum = 10'h000;
    next_st = st;
    sclRise = st.sclSync[1] && !st.sclPrev;
    sclFall = !st.sclSync[1] && st.sclPrev;
    startCond = st.sclSync[1] && st.sclPrev && st.sdaPrev && !st.sdaSync[1];
    stopCond = st.sclSync[1] && st.sclPrev && !st.sdaPrev && st.sdaSync[1];
    syncTrail = !st.lineSyncS[1] && st.lineSyncPrev;
    readData = readReg(st, st.pointer);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    next_st.sclSync = {st.sclSync[0], sclIn};
    next_st.sdaSync = {st.sdaSync[0], sdaIn};
    next_st.addrSync = {st.addrSync[0], addrPin};
    next_st.lineSyncS = {st.lineSyncS[0], lineSync};
    next_st.strobeSync = {st.strobeSync[0], clampStrobe};
    next_st.greenSync = {st.greenSync[0], greenSyncInput};
    next_st.sclPrev = st.sclSync[1];
    next_st.sdaPrev = st.sdaSync[1];
    next_st.lineSyncPrev = st.lineSyncS[1];

    // ----------------------------------------------------------------
    // Two-wire register port
    // ----------------------------------------------------------------
    // sole access path
    if (startCond) begin
      next_st.port = SP_ADDR;
      next_st.bitCnt = 4'h0;
      next_st.subAddrNext = 1'b1;
      next_st.sdaDrive = 1'b0;
    end else if (stopCond) begin
      next_st.port = SP_IDLE;
      next_st.sdaDrive = 1'b0;
    end else begin
      unique case (st.port)
        SP_IDLE: begin
          next_st.sdaDrive = 1'b0;
        end
        SP_ADDR, SP_WRITE: begin
          if (sclRise) begin
            next_st.shift = {st.shift[6:0], st.sdaSync[1]};
            next_st.bitCnt = st.bitCnt + 4'h1;
          end else if (sclFall && st.bitCnt == 4'h8) begin
            next_st.bitCnt = 4'h0;
            if (st.port == SP_ADDR) begin
              if (st.shift[7:1] == {`VCT_DEV_ADDR_BASE, st.addrSync[1]}) begin
                next_st.port = SP_ADDR_ACK;
                next_st.readDir = st.shift[0];
                next_st.sdaDrive = 1'b1;
              end else begin
                next_st.port = SP_IDLE;
              end
            end else begin
              next_st.port = SP_WRITE_ACK;
              next_st.sdaDrive = 1'b1;
              if (st.subAddrNext) begin
                next_st.pointer = st.shift;
                next_st.subAddrNext = 1'b0;
              end else begin
                next_st.pointer = st.pointer + 8'h01;
                unique case (st.pointer)
                  `VCT_REG_CLAMP_START_DELAY: next_st.clampStart = st.shift;
                  `VCT_REG_CLAMP_LENGTH: next_st.clampLength = st.shift;
                  `VCT_REG_RED_FULL_SCALE: next_st.fullScale[0] = st.shift;
                  `VCT_REG_GREEN_FULL_SCALE: next_st.fullScale[1] = st.shift;
                  `VCT_REG_BLUE_FULL_SCALE: next_st.fullScale[2] = st.shift;
                  `VCT_REG_RED_LEVEL_SHIFT: next_st.levelShift[0] = st.shift[6:0];
                  `VCT_REG_GREEN_LEVEL_SHIFT: next_st.levelShift[1] = st.shift[6:0];
                  `VCT_REG_BLUE_LEVEL_SHIFT: next_st.levelShift[2] = st.shift[6:0];
                  `VCT_REG_BANDWIDTH: next_st.bandwidth = st.shift[`VCT_BW_MSB:0];
                  `VCT_REG_CLAMP_CTRL: next_st.clampCtrl = st.shift;
                  `VCT_REG_SYNC_CTRL: next_st.syncCtrl = st.shift;
                  default: next_st.clampCtrl = st.clampCtrl;
                endcase
              end
            end
          end
        end
        SP_ADDR_ACK, SP_READ_ACK: begin
          if (sclRise) begin
            next_st.masterNack = st.sdaSync[1];
          end else if (sclFall) begin
            if ((st.port == SP_ADDR_ACK && st.readDir) ||
                (st.port == SP_READ_ACK && !st.masterNack)) begin
              next_st.port = SP_READ;
              next_st.shift = readData;
              next_st.pointer = st.pointer + 8'h01;
              next_st.bitCnt = 4'h0;
              next_st.sdaDrive = !readData[7];
            end else if (st.port == SP_ADDR_ACK) begin
              next_st.port = SP_WRITE;
              next_st.sdaDrive = 1'b0;
            end else begin
              next_st.port = SP_IDLE;
              next_st.sdaDrive = 1'b0;
            end
          end
        end
        SP_WRITE_ACK: begin
          if (sclFall) begin
            next_st.port = SP_WRITE;
            next_st.sdaDrive = 1'b0;
          end
        end
        SP_READ: begin
          if (sclFall) begin
            if (st.bitCnt == 4'h7) begin
              next_st.port = SP_READ_ACK;
              next_st.sdaDrive = 1'b0;
            end else begin
              next_st.sdaDrive = !st.shift[6];
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.bitCnt = st.bitCnt + 4'h1;
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Internal clamp timing generator
    // ----------------------------------------------------------------
    // restart on edge
    if (syncTrail) begin
      next_st.gen = CG_DELAY;
      next_st.genCnt = 8'h00;
    end else begin
      unique case (st.gen)
        CG_IDLE: begin
          next_st.genCnt = 8'h00;
        end
        CG_DELAY: begin
          if (st.genCnt == st.clampStart) begin
            next_st.gen = (st.clampLength == 8'h00) ? CG_IDLE : CG_ACTIVE;
            next_st.genCnt = 8'h00;
          end else begin
            next_st.genCnt = st.genCnt + 8'h01;
          end
        end
        CG_ACTIVE: begin
          if (st.genCnt == st.clampLength - 8'h01) begin
            next_st.gen = CG_IDLE;
            next_st.genCnt = 8'h00;
          end else begin
            next_st.genCnt = st.genCnt + 8'h01;
          end
        end
      endcase
    end

    // strobe polarity, set means active low
    extClamp = st.strobeSync[1] ^ st.clampCtrl[`VCT_CLAMP_POL_BIT];
    clampNow = st.clampCtrl[`VCT_CLAMP_SRC_BIT] ? extClamp : (next_st.gen == CG_ACTIVE);
    next_st.clampActive = clampNow;

    // ----------------------------------------------------------------
    // Black level trim
    // ----------------------------------------------------------------
    // red and blue midscale selects
    midSel = {st.syncCtrl[`VCT_BLUE_MID_BIT], 1'b0, st.syncCtrl[`VCT_RED_MID_BIT]};
    for (int i = 0; i < 3; i++) begin
      target[i] = midSel[i] ? `VCT_CODE_MIDSCALE : `VCT_CODE_BLACK;
      sum = {2'b00, rawCode[i]} + {st.trim[i][8], st.trim[i]};
      if (sum[9]) begin
        next_st.codeOut[i] = 8'h00;
      end else if (sum[8]) begin
        next_st.codeOut[i] = 8'hff;
      end else begin
        next_st.codeOut[i] = sum[7:0];
      end
      if (st.clampActive) begin
        if (next_st.codeOut[i] > target[i] && st.trim[i] != 9'h100) begin
          next_st.trim[i] = st.trim[i] - 9'h001;
        end else if (next_st.codeOut[i] < target[i] && st.trim[i] != 9'h0ff) begin
          next_st.trim[i] = st.trim[i] + 9'h001;
        end
      end
    end

    next_st.greenSyncDetect = !st.greenSync[1];

    if (!rst_b) begin
      next_st = '0;
      next_st.port = SP_IDLE;
      next_st.gen = CG_IDLE;
      next_st.clampStart = `VCT_CLAMP_START_RST;
      next_st.clampLength = `VCT_CLAMP_LENGTH_RST;
      next_st.syncCtrl = `VCT_SYNC_CTRL_RST;
      for (int i = 0; i < 3; i++) begin
        next_st.fullScale[i] = `VCT_FULL_SCALE_RST;
        next_st.levelShift[i] = `VCT_LEVEL_SHIFT_RST;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdaOut = 1'b0;
  assign sdaOe_b = !st.sdaDrive;
  assign clampActive = st.clampActive;
  assign redCode = st.codeOut[0];
  assign greenCode = st.codeOut[1];
  assign blueCode = st.codeOut[2];
  assign redFullScale = st.fullScale[0];
  assign greenFullScale = st.fullScale[1];
  assign blueFullScale = st.fullScale[2];
  assign redLevelShift = shiftLsb(st.levelShift[0]);
  assign greenLevelShift = shiftLsb(st.levelShift[1]);
  assign blueLevelShift = shiftLsb(st.levelShift[2]);
  assign bandwidthSel = st.bandwidth;
  assign greenSyncThreshold = st.syncCtrl[`VCT_SOG_THR_MSB:`VCT_SOG_THR_LSB];
  assign greenSyncDetect = st.greenSyncDetect;

endmodule

`default_nettype wire

// ---- hw/vct_params.svh ----
// Register offsets, field positions, reset values and constants of the clamp and level control.
`ifndef VCT_PARAMS_SVH
`define VCT_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VCT_REG_CLAMP_START_DELAY 8'h05
`define VCT_REG_CLAMP_LENGTH 8'h06
`define VCT_REG_RED_FULL_SCALE 8'h08
`define VCT_REG_GREEN_FULL_SCALE 8'h09
`define VCT_REG_BLUE_FULL_SCALE 8'h0a
`define VCT_REG_RED_LEVEL_SHIFT 8'h0b
`define VCT_REG_GREEN_LEVEL_SHIFT 8'h0c
`define VCT_REG_BLUE_LEVEL_SHIFT 8'h0d
`define VCT_REG_BANDWIDTH 8'h0e
`define VCT_REG_CLAMP_CTRL 8'h0f
`define VCT_REG_SYNC_CTRL 8'h10
`define VCT_REG_STATUS 8'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCT_CLAMP_SRC_BIT 7
`define VCT_CLAMP_POL_BIT 6
`define VCT_RED_MID_BIT 1
`define VCT_BLUE_MID_BIT 2
`define VCT_SOG_THR_MSB 7
`define VCT_SOG_THR_LSB 3
`define VCT_BW_MSB 1

// ----------------------------------------------------------------
// Reset values and levels
// ----------------------------------------------------------------
`define VCT_CLAMP_START_RST 8'h08
`define VCT_CLAMP_LENGTH_RST 8'h14
`define VCT_FULL_SCALE_RST 8'h80
`define VCT_LEVEL_SHIFT_RST 7'h40
`define VCT_SYNC_CTRL_RST 8'h80
`define VCT_LEVEL_SHIFT_ZERO 7'h40
`define VCT_LEVEL_SHIFT_MAX 7'h3f
`define VCT_LEVEL_SHIFT_MIN 7'h41
`define VCT_CODE_BLACK 8'h00
`define VCT_CODE_MIDSCALE 8'h80
`define VCT_DEV_ADDR_BASE 6'h15

`endif

// ---- hw/vct_pkg.sv ----
// Types shared by the clamp and level control.
package vct_pkg;
  typedef logic [7:0] code_t;
  typedef enum logic [2:0] {SP_IDLE, SP_ADDR, SP_ADDR_ACK, SP_WRITE, SP_WRITE_ACK, SP_READ,
                            SP_READ_ACK} vct_port_e;
  typedef enum logic [1:0] {CG_IDLE, CG_DELAY, CG_ACTIVE} vct_gen_e;
  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] addrSync;
    logic [1:0] lineSyncS;
    logic [1:0] strobeSync;
    logic [1:0] greenSync;
    logic sclPrev;
    logic sdaPrev;
    logic lineSyncPrev;
    vct_port_e port;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic subAddrNext;
    logic readDir;
    logic masterNack;
    logic sdaDrive;
    vct_gen_e gen;
    logic [7:0] genCnt;
    logic clampActive;
    logic [7:0] clampStart;
    logic [7:0] clampLength;
    logic [2:0][7:0] fullScale;
    logic [2:0][6:0] levelShift;
    logic [1:0] bandwidth;
    logic [7:0] clampCtrl;
    logic [7:0] syncCtrl;
    logic [2:0][8:0] trim;
    logic [2:0][7:0] codeOut;
    logic greenSyncDetect;
  } vct_state_s;
endpackage
